//--- tb/ceq_core_event_qualifier_test.sv
// Self-checking bench: register bus tasks, load filter and off-core filter.
// Assumes the design answers AXI4-Lite requests and a model drives events.
`timescale 1ns/1ps
module ceq_core_event_qualifier_test;
  import ceq_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [15:0] sample_latency;
  logic sample_valid, offcore_hit;
  ceq_load_t ld_cmd = '0;
  ceq_offc_t oc_cmd = '0;
  ceq_load_t load_evt;
  ceq_offc_t offc_evt;
  logic [15:0] sel_shadow = 16'h0;
  int n_mismatch = 0, checks_done = 0, n_samp = 0, seed = 95;
  always #20 aclk = ~aclk;
  ceq_core_event_qualifier dut (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .load_evt(load_evt),
    .offc_evt(offc_evt),
    .sample_latency(sample_latency),
    .sample_valid(sample_valid),
    .offcore_hit(offcore_hit)
  );
  ceq_core_model model (
    .aclk(aclk),
    .aresetn(aresetn),
    .ld_cmd(ld_cmd),
    .oc_cmd(oc_cmd),
    .load_evt(load_evt),
    .offc_evt(offc_evt)
  );
  // ---------------------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic hang();
    n_mismatch++;
    $display("MISMATCH %0t wait ran out", $time);
    end_sim();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wchk(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (k == 40) hang();
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    s_axi_bready <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    int k;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    // Ready is raised only once the answer shows, so the slave must hold it a cycle.
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    if (k == 40) hang();
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'b0;
  endtask
  function automatic logic exp_hit(input logic [15:0] s, input ceq_offc_t t);
    int b;
    b = t.rsp < 3 ? 8 + t.rsp : 9 + t.rsp;
    return t.valid && s[t.req] && t.rsp != CEQ_RSP_NONE && s[b];
  endfunction
  always @(posedge aclk) begin
    if (sample_valid === 1'b1) n_samp++;
    if (offc_evt.valid === 1'b1) chk({31'h0, offcore_hit}, {31'h0, exp_hit(sel_shadow, offc_evt)});
  end
  initial begin
    repeat (60000) @(posedge aclk);
    hang();
  end
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    ceq_load_t l;
    ceq_offc_t o;
    logic [15:0] thr, lat_exp;
    logic [11:0] ca;
    logic [5:0] oc_last;
    int i, p, idx, base, n_exp;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(CEQ_ADDR_LAT_THR, 32'h3, CEQ_RESP_OKAY);
    rchk(CEQ_ADDR_OFFCORE, 32'h0, CEQ_RESP_OKAY);
    rchk(12'h100, 32'h0, CEQ_RESP_SLVERR);
    wchk(12'h100, 32'hFFFFFFFF, CEQ_RESP_SLVERR);
    s_axi_wstrb <= 4'h2;
    wchk(CEQ_ADDR_LAT_THR, 32'h0000_7700, CEQ_RESP_OKAY);
    rchk(CEQ_ADDR_LAT_THR, {16'h0, 8'h77, CEQ_LAT_THR_RESET[7:0]}, CEQ_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    $display("test reset and map done");
    thr = 16'h0003 + 16'($unsigned($random(seed)) % 17);
    wchk(CEQ_ADDR_LAT_THR, {16'hABCD, thr}, CEQ_RESP_OKAY);
    rchk(CEQ_ADDR_LAT_THR, {16'h0, thr}, CEQ_RESP_OKAY);
    wchk(CEQ_ADDR_EVSEL0, 32'h100, CEQ_RESP_OKAY);
    wchk(CEQ_ADDR_CNT0, 32'h0, CEQ_RESP_OKAY);
    base = n_samp;
    n_exp = 0;
    for (i = 0; i < 64; i++) begin
      @(posedge aclk);
      l.valid = i < 3 || $unsigned($random(seed)) % 4 != 0;
      l.is_store = i == 2 || $unsigned($random(seed)) % 5 == 0;
      l.latency = i == 0 ? thr : i == 1 ? thr + 16'h1 : 16'($unsigned($random(seed)) % 48);
      if (l.valid && !l.is_store && l.latency > thr) begin
        n_exp++;
        lat_exp = l.latency;
      end
      ld_cmd <= l;
    end
    @(posedge aclk);
    ld_cmd <= '0;
    repeat (3) @(posedge aclk);
    chk(n_samp - base, n_exp);
    rchk(CEQ_ADDR_CNT0, n_exp, CEQ_RESP_OKAY);
    chk({16'h0, sample_latency}, {16'h0, lat_exp});
    rchk(CEQ_ADDR_LAST_LAT, {16'h0, lat_exp}, CEQ_RESP_OKAY);
    wchk(CEQ_ADDR_LAST_LAT, 32'h0, CEQ_RESP_SLVERR);
    $display("test load filter done");
    idx = $unsigned($random(seed)) % 4;
    ca = CEQ_ADDR_CNT0 + 12'(idx * 4);
    wchk(CEQ_ADDR_EVSEL0 + 12'(idx * 4), 32'hB7, CEQ_RESP_OKAY);
    wchk(ca, 32'h0, CEQ_RESP_OKAY);
    n_exp = 0;
    oc_last = 6'h00;
    for (p = 0; p < 22; p++) begin
      sel_shadow = p < 8 ? 16'h1 << p | 16'hFF00 : 16'($random(seed));
      if (p >= 8 && p < 16) sel_shadow = 16'h1 << p | 16'h00FF;
      wchk(CEQ_ADDR_OFFCORE, {16'h5A5A, sel_shadow}, CEQ_RESP_OKAY);
      rchk(CEQ_ADDR_OFFCORE, {16'h0, sel_shadow}, CEQ_RESP_OKAY);
      for (i = 0; i < 64; i++) begin
        @(posedge aclk);
        o = {1'b1, 3'(i >> 3), 3'(i)};
        if (exp_hit(sel_shadow, o)) begin
          n_exp++;
          oc_last = {o.rsp, o.req};
        end
        oc_cmd <= o;
      end
      @(posedge aclk);
      oc_cmd <= '0;
      repeat (2) @(posedge aclk);
    end
    rchk(ca, n_exp, CEQ_RESP_OKAY);
    rchk(CEQ_ADDR_LAST_OFFC, {26'h0, oc_last}, CEQ_RESP_OKAY);
    $display("test offcore filter done");
    end_sim();
  end
endmodule // ceq_core_event_qualifier_test
bind ceq_core_event_qualifier ceq_monitor u_mon (
  .aclk(aclk),
  .aresetn(aresetn),
  .load_evt(load_evt),
  .offc_evt(offc_evt),
  .sample_latency(sample_latency),
  .sample_valid(sample_valid),
  .offcore_hit(offcore_hit),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready)
);

//--- tb/ceq_core_model.sv
// Memory pipeline model: turns bench commands into one-cycle event pulses.
// Assumes commands change just after a rising edge of aclk.
`timescale 1ns/1ps
module ceq_core_model
  import ceq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire ceq_load_t ld_cmd,
  input wire ceq_offc_t oc_cmd,
  output ceq_load_t load_evt,
  output ceq_offc_t offc_evt
);
  // Idle slots carry the inverse payload so stale fields never look steady.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_evt <= '0;
      offc_evt <= '0;
    end else begin
      load_evt <= ld_cmd.valid ? ld_cmd : {1'b0, ~load_evt.is_store, ~load_evt.latency};
      offc_evt <= oc_cmd.valid ? oc_cmd : {1'b0, ~offc_evt.req, ~offc_evt.rsp};
    end
  end
endmodule // ceq_core_model

//--- tb/ceq_monitor.sv
// Checker for the core event qualifier, watching top-level ports only.
// Assumes it is bound into the top module and sees a single clock domain.
`timescale 1ns/1ps
module ceq_monitor
  import ceq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire ceq_load_t load_evt,
  input wire ceq_offc_t offc_evt,
  input wire logic [15:0] sample_latency,
  input wire logic sample_valid,
  input wire logic offcore_hit,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  sequence s_good_load;
    load_evt.valid && !load_evt.is_store && load_evt.latency >= CEQ_MIN_DETECT_LAT;
  endsequence
  sequence s_rd_wait;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  a_sample_from_load: assert property (sample_valid |-> $past(load_evt.valid))
    else $error("sample without a load");
  a_sample_latency_match: assert property (
    s_good_load ##1 sample_valid |-> sample_latency == $past(load_evt.latency))
    else $error("sampled latency differs from load");
  a_latency_holds: assert property (!sample_valid |-> $stable(sample_latency))
    else $error("sampled latency moved without a sample");
  a_store_dropped: assert property (load_evt.valid && load_evt.is_store |=> !sample_valid)
    else $error("store produced a sample");
  a_short_dropped: assert property (
    load_evt.valid && load_evt.latency < CEQ_MIN_DETECT_LAT |=> !sample_valid)
    else $error("undetectable latency produced a sample");
  a_hit_needs_evt: assert property (offcore_hit |-> offc_evt.valid)
    else $error("hit without a transaction");
  a_hit_none_rsp: assert property (offc_evt.rsp == CEQ_RSP_NONE |-> !offcore_hit)
    else $error("hit on an unselectable response");
  a_read_held: assert property (s_rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped before taken");
endmodule // ceq_monitor

//--- verilog/ceq_core_event_qualifier.sv
// Core event qualifier: load latency threshold filter and off-core response filter,
// four event selects with counters, all behind an AXI4-Lite slave.
// Assumes load and off-core event inputs are one-cycle pulses synchronous to aclk.
//
// Summary of operation
// - Latency threshold register holds a 16-bit threshold in core cycles, low bits.
// - Loads with latency strictly above threshold are counted and their latency sampled.
// - One off-core response configuration register alone qualifies off-core events.
// - Configuration bits 7:0 select qualifying request types.
// - Configuration bits 15:8 select qualifying response types.
// - Bits 0,1,2 select demand data reads, demand ownership reads, demand code reads.
// - Bit 3 selects writeback transactions.
// - Bits 4,5,6 select prefetcher data, ownership and code reads.
// - Bit 7 selects all other transaction types.
// - Bits 8,9,10 select L3 hits: no snoop, clean snoop, modified snoop; 11 reserved.
// - Bits 12,13,14 select L3 misses: forwarded, remote DRAM, local DRAM.
// - Bit 15 selects non-DRAM requests served by the I/O hub.
// - Stores are excluded while the latency event is selected.
// - Smallest detectable load latency is four core cycles.
`timescale 1ns/1ps
module ceq_core_event_qualifier
  import ceq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire ceq_load_t load_evt,
  input wire ceq_offc_t offc_evt,
  output logic [15:0] sample_latency,
  output logic sample_valid,
  output logic offcore_hit
);

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  logic [15:0] lat_thr_q;
  logic [15:0] offcore_sel_q;
  logic [31:0] evsel_q [CEQ_NUM_CTR];
  logic [31:0] cnt_q [CEQ_NUM_CTR];
  logic [15:0] last_lat_q;
  logic [5:0] last_offc_q;
  logic [15:0] sample_latency_q;
  logic sample_valid_q;

  // ---------------------------------------------------------------------------
  // Write channel
  // ---------------------------------------------------------------------------
  logic aw_held_q;
  logic w_held_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic wr_fire;
  logic wr_ok;

  // Address and data may arrive in either order; each is held until both are present.
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  function automatic logic ceq_is_ctr(input logic [11:0] a, input logic [11:0] base);
    ceq_is_ctr = (a[11:4] == base[11:4]) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [31:0] ceq_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
    ceq_merge = old;
  endfunction

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  // One decode feeds both channels, so a register can never be writable at one
  // address and readable at another.
  typedef struct packed {
    logic lat_thr;
    logic offcore;
    logic evsel;
    logic cnt;
    logic last_lat;
    logic last_offc;
  } ceq_dec_t;

  function automatic ceq_dec_t ceq_decode(input logic [11:0] a);
    ceq_dec_t d;
    d.lat_thr = (a == CEQ_ADDR_LAT_THR);
    d.offcore = (a == CEQ_ADDR_OFFCORE);
    d.evsel = ceq_is_ctr(a, CEQ_ADDR_EVSEL0);
    d.cnt = ceq_is_ctr(a, CEQ_ADDR_CNT0);
    d.last_lat = (a == CEQ_ADDR_LAST_LAT);
    d.last_offc = (a == CEQ_ADDR_LAST_OFFC);
    return d;
  endfunction

  ceq_dec_t wr_dec;
  ceq_dec_t rd_dec;

  assign wr_dec = ceq_decode(awaddr_q);
  assign rd_dec = ceq_decode(s_axi_araddr);

  // The two capture registers are read-only; a write to them is refused with an error.
  always_comb begin
    wr_ok = wr_dec.lat_thr || wr_dec.offcore || wr_dec.evsel || wr_dec.cnt;
  end

  // A write is answered one cycle after both halves are held; the response then stands
  // until the master takes it, and no new address or data is accepted meanwhile.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= CEQ_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_ok ? CEQ_RESP_OKAY : CEQ_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  logic [31:0] merged;
  assign merged = ceq_merge({16'h0000, lat_thr_q}, wdata_q, wstrb_q);

  // A threshold under the documented minimum is software's fault; it is stored as written.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lat_thr_q <= CEQ_LAT_THR_RESET;
    end else if (wr_fire && wr_dec.lat_thr) begin
      lat_thr_q <= merged[15:0];
    end
  end

  logic [31:0] merged_offc;
  assign merged_offc = ceq_merge({16'h0000, offcore_sel_q}, wdata_q, wstrb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      offcore_sel_q <= CEQ_OFFCORE_RESET;
    end else if (wr_fire && wr_dec.offcore) begin
      offcore_sel_q <= merged_offc[15:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Event qualification
  // ---------------------------------------------------------------------------
  logic offc_match;
  logic load_hit;

  ceq_offcore_match u_match (
    .sel(offcore_sel_q),
    .txn(offc_evt),
    .hit(offc_match)
  );

  // Latencies under the detectable floor never register, whatever the threshold.
  assign load_hit = load_evt.valid && !load_evt.is_store &&
                    load_evt.latency >= CEQ_MIN_DETECT_LAT &&
                    load_evt.latency > lat_thr_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_latency_q <= 16'h0000;
      sample_valid_q <= 1'b0;
    end else begin
      sample_valid_q <= load_hit;
      if (load_hit) begin
        sample_latency_q <= load_evt.latency;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Capture registers
  // ---------------------------------------------------------------------------
  // Software reads these long after the pulse outputs have moved on, so each keeps
  // the last qualifying event until the next one.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_lat_q <= 16'h0000;
    end else if (load_hit) begin
      last_lat_q <= load_evt.latency;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_offc_q <= 6'h00;
    end else if (offc_match) begin
      last_offc_q <= {offc_evt.rsp, offc_evt.req};
    end
  end

  // ---------------------------------------------------------------------------
  // Event outputs
  // ---------------------------------------------------------------------------
  assign sample_latency = sample_latency_q;
  assign sample_valid = sample_valid_q;
  assign offcore_hit = offc_match;

  // ---------------------------------------------------------------------------
  // Event selects and counters
  // ---------------------------------------------------------------------------
  // Any of the four selects may carry the off-core code; all share the one configuration.
  for (genvar g = 0; g < CEQ_NUM_CTR; g++) begin : g_ctr
    logic sel_wr;
    logic cnt_wr;
    logic inc;
    logic [11:0] ev_addr;
    logic [11:0] ct_addr;
    assign ev_addr = CEQ_ADDR_EVSEL0 + 12'(g << CEQ_CTR_SHIFT);
    assign ct_addr = CEQ_ADDR_CNT0 + 12'(g << CEQ_CTR_SHIFT);
    assign sel_wr = wr_fire && awaddr_q == ev_addr;
    assign cnt_wr = wr_fire && awaddr_q == ct_addr;
    assign inc = (evsel_q[g][7:0] == CEQ_EV_OFFCORE && offc_match) ||
                 (evsel_q[g][15:0] == CEQ_EV_LOAD_LAT && load_hit);

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        evsel_q[g] <= 32'h0000_0000;
      end else if (sel_wr) begin
        evsel_q[g] <= ceq_merge(evsel_q[g], wdata_q, wstrb_q) & CEQ_EVSEL_MASK;
      end
    end

    // Counters wrap silently at their full width; there is no overflow flag here,
    // so software must read them often enough to tell a wrap from a quiet period.
    // An increment in the cycle of a software write is dropped; the write wins.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cnt_q[g] <= 32'h0000_0000;
      end else if (cnt_wr) begin
        cnt_q[g] <= ceq_merge(cnt_q[g], wdata_q, wstrb_q);
      end else if (inc) begin
        cnt_q[g] <= cnt_q[g] + 32'h0000_0001;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------------------
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [31:0] rd_val;
  logic rd_ok;

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    if (rd_dec.lat_thr) begin
      rd_val = {16'h0000, lat_thr_q};
    end else if (rd_dec.offcore) begin
      rd_val = {16'h0000, offcore_sel_q};
    end else if (rd_dec.evsel) begin
      rd_val = evsel_q[s_axi_araddr[3:2]];
    end else if (rd_dec.cnt) begin
      rd_val = cnt_q[s_axi_araddr[3:2]];
    end else if (rd_dec.last_lat) begin
      rd_val = {16'h0000, last_lat_q};
    end else if (rd_dec.last_offc) begin
      rd_val = {26'h0000000, last_offc_q};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Read data is captured at the address handshake, so a counter read shows the value
  // from before any increment at that same edge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= CEQ_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_ok ? CEQ_RESP_OKAY : CEQ_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule // ceq_core_event_qualifier

//--- verilog/ceq_offcore_match.sv
// Off-core transaction matcher: one-hot request and response decode against the selection.
// Assumes request and response codes come from the core memory pipeline in the same cycle.
`timescale 1ns/1ps
module ceq_offcore_match
  import ceq_pkg::*;
(
  input wire logic [15:0] sel,
  input wire ceq_offc_t txn,
  output logic hit
);

  function automatic logic [7:0] ceq_onehot(input logic [2:0] code);
    ceq_onehot = 8'h01 << code;
  endfunction

  logic [7:0] req_vec;
  logic [7:0] rsp_vec;
  logic [7:0] rsp_sel;

  // Response code 7 is "none" and decodes to no bit at all; the reserved position, bit 11, is masked off.
  always_comb begin
    req_vec = ceq_onehot(txn.req);
    rsp_vec = (txn.rsp == CEQ_RSP_NONE) ? 8'h00 :
              (txn.rsp < CEQ_RSP_MISS_FWD) ? ceq_onehot(txn.rsp) :
              ceq_onehot(3'(txn.rsp + 3'h1));
    rsp_sel = sel[15:8] & CEQ_RSP_USED_MASK;
  end

  assign hit = txn.valid && |(req_vec & sel[7:0]) && |(rsp_vec & rsp_sel);

endmodule // ceq_offcore_match

//--- verilog/ceq_pkg.sv
// Package for the core event qualifier: register map, field layout, event codes, types.
// Assumes a 32-bit AXI4-Lite register bus and a single core clock domain.
package ceq_pkg;

  // ---------------------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------------------
  localparam int unsigned CEQ_ADDR_W = 12;
  localparam logic [11:0] CEQ_OFFCORE_RSP_INDEX = 12'h1A6;
  localparam logic [11:0] CEQ_ADDR_OFFCORE = 12'h698;
  localparam logic [11:0] CEQ_ADDR_LAT_THR = 12'h000;
  localparam logic [11:0] CEQ_ADDR_EVSEL0 = 12'h010;
  localparam logic [11:0] CEQ_ADDR_CNT0 = 12'h020;
  localparam logic [11:0] CEQ_ADDR_LAST_LAT = 12'h030;
  localparam logic [11:0] CEQ_ADDR_LAST_OFFC = 12'h034;
  localparam int unsigned CEQ_NUM_CTR = 4;
  localparam int unsigned CEQ_CTR_SHIFT = 2;

  // ---------------------------------------------------------------------------
  // Field layout and codes
  // ---------------------------------------------------------------------------
  localparam logic [15:0] CEQ_LAT_THR_RESET = 16'h0003;
  localparam logic [15:0] CEQ_OFFCORE_RESET = 16'h0000;
  localparam logic [15:0] CEQ_MIN_DETECT_LAT = 16'h0004;
  localparam logic [7:0] CEQ_EV_OFFCORE = 8'hB7;
  localparam logic [15:0] CEQ_EV_LOAD_LAT = 16'h0100;
  localparam logic [7:0] CEQ_RSP_USED_MASK = 8'hF7;
  localparam logic [31:0] CEQ_EVSEL_MASK = 32'h0000FFFF;
  localparam logic [1:0] CEQ_RESP_OKAY = 2'h0;
  localparam logic [1:0] CEQ_RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------------------
  // Transaction carriers
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    CEQ_REQ_DEMAND_DATA,
    CEQ_REQ_DEMAND_RFO,
    CEQ_REQ_DEMAND_CODE,
    CEQ_REQ_WRITEBACK,
    CEQ_REQ_PF_DATA,
    CEQ_REQ_PREFETCH_OWNERSHIP_READ_SEL,
    CEQ_REQ_PF_CODE,
    CEQ_REQ_OTHER
  } ceq_req_t;

  typedef enum logic [2:0] {
    CEQ_RSP_L3_HIT,
    CEQ_RSP_L3_HIT_CLEAN,
    CEQ_RSP_L3_HIT_MOD,
    CEQ_RSP_MISS_FWD,
    CEQ_RSP_REMOTE_DRAM,
    CEQ_RSP_LOCAL_DRAM,
    CEQ_RSP_IO_HUB,
    CEQ_RSP_NONE
  } ceq_rsp_t;

  typedef struct packed {
    logic valid;
    logic is_store;
    logic [15:0] latency;
  } ceq_load_t;

  typedef struct packed {
    logic valid;
    ceq_req_t req;
    ceq_rsp_t rsp;
  } ceq_offc_t;

endpackage
